//--- asp_pkg.sv
package asp_pkg;

	// ======================================================================
	// Register map.
	localparam logic [3:0] ASP_ADDR_SETPOINT  = 4'h0;
	localparam logic [3:0] ASP_ADDR_AUXREF    = 4'h1;
	localparam logic [3:0] ASP_ADDR_PERIPH_EN = 4'h2;
	localparam logic [3:0] ASP_ADDR_TEST_CTL  = 4'h3;
	localparam logic [3:0] ASP_ADDR_STATUS    = 4'h4;

	// ======================================================================
	// Reset values.
	localparam logic [7:0] ASP_RST_SETPOINT  = 8'h00;
	localparam logic [7:0] ASP_RST_AUXREF    = 8'h00;
	localparam logic [7:0] ASP_RST_PERIPH_EN = 8'h00;
	localparam logic [7:0] ASP_RST_TEST_CTL  = 8'h00;

	// ======================================================================
	// Peripheral enable field positions.
	localparam int ASP_PE_PRI_EN     = 7;
	localparam int ASP_PE_SEC_EN     = 6;
	localparam int ASP_PE_PRI_BYPASS = 5;
	localparam int ASP_PE_SEC_BYPASS = 4;
	localparam int ASP_PE_PULLUP     = 2;
	localparam int ASP_PE_PRI_STEER  = 1;
	localparam int ASP_PE_SEC_STEER  = 0;
	localparam logic [7:0] ASP_PE_WMASK = 8'hF7;

	// ======================================================================
	// Test control field positions.
	localparam int ASP_TC_DIG_EN  = 7;
	localparam int ASP_TC_SEL_LSB = 4;
	localparam int ASP_TC_ANA_EN  = 0;
	localparam logic [7:0] ASP_TC_WMASK = 8'hF1;

	// ======================================================================
	// Operating mode and test select codes.
	localparam logic [1:0] ASP_MODE_MASTER = 2'h1;
	localparam logic [2:0] ASP_SEL_DESATURATION_COMPARATOR   = 3'h0;
	localparam logic [2:0] ASP_SEL_PWM     = 3'h1;
	localparam logic [2:0] ASP_SEL_OVP     = 3'h4;
	localparam logic [2:0] ASP_SEL_SWFREQ  = 3'h5;
	localparam logic [2:0] ASP_SEL_ONESHOT = 3'h6;

	// ======================================================================
	// Bus carriers.
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} asp_bus_req_t;

	typedef struct packed {
		logic pri_gate;
		logic sec_gate;
		logic pri_dt_bypass;
		logic sec_dt_bypass;
		logic sense_pullup;
	} asp_analog_ctl_t;

endpackage

//--- asp_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Hold 8-bit regulation set-point code for the linear reference DAC.
// - Hold 8-bit auxiliary reference code, ground-referenced DAC.
// - Auxiliary reference reaches its pin only in master mode 01.
// - Bits 7 and 6 enable primary and secondary gate outputs.
// - Bits 5 and 4 bypass the per-driver turn-on dead time.
// - Bit 2 enables weak pull-up on the secondary current sense input.
// - Bit 1 drives primary output with open-loop PWM to raise output.
// - Bit 0 pulses secondary with PWM only while overvoltage protection active.
// - Steering PWM comes from timer period and timer low byte.
// - Primary steering wins when both steering bits are set.
// - Digital test enable routes selected digital channel to test pin.
// - Digital test output has priority over analog on the test pin.
// - Analog-only test enable routes analog signals to internal converter.
// - Select codes 0,1,4,5,6 pick documented signals; others unimplemented.
module asp_regs
	import asp_pkg::*;
(
	input  wire logic            mclk,
	input  wire logic            rst,
	input  wire asp_bus_req_t    bus_req,
	output logic [7:0]           bus_rdata,
	input  wire logic [1:0]      operating_mode_select,
	input  wire logic            ovp_active,
	input  wire logic [7:0]      timer_period_register,
	input  wire logic [7:0]      timer_low_byte,
	input  wire logic [7:0]      test_sig_in,
	output logic [7:0]           setpoint_code,
	output logic [7:0]           aux_reference_code,
	output logic                 aux_reference_pin_en,
	output asp_analog_ctl_t      analog_ctl,
	output logic                 primary_gate_output,
	output logic                 secondary_gate_output,
	output logic                 shared_test_pin,
	output logic                 shared_test_pin_oe,
	output logic                 analog_test_to_pin,
	output logic                 analog_test_to_converter
);

	// ======================================================================
	// State.
	typedef struct packed {
		logic [7:0] setpoint;
		logic [7:0] auxref;
		logic [7:0] periph;
		logic [7:0] testctl;
		logic [7:0] rdata;
		logic [7:0] pwm_cnt;
		logic       pwm_out;
		logic       test_out;
		logic       test_oe;
		logic       pri_gate;
		logic       sec_gate;
	} asp_state_t;

	asp_state_t state_reg;
	asp_state_t state_next;
	logic [1:0] mode_s1_reg;
	logic [1:0] mode_s2_reg;
	logic       ovp_s1_reg;
	logic       ovp_s2_reg;
	logic [7:0] test_s1_reg;
	logic [7:0] test_s2_reg;
	logic       pri_steer;
	logic       sec_steer;
	logic [2:0] digital_test_select;
	logic       dig_en;
	logic       ana_en;

	// ======================================================================
	// Input synchronisers.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_s1_reg <= 2'h0;
			mode_s2_reg <= 2'h0;
			ovp_s1_reg  <= 1'b0;
			ovp_s2_reg  <= 1'b0;
			test_s1_reg <= 8'h00;
			test_s2_reg <= 8'h00;
		end else begin
			mode_s1_reg <= operating_mode_select;
			mode_s2_reg <= mode_s1_reg;
			ovp_s1_reg  <= ovp_active;
			ovp_s2_reg  <= ovp_s1_reg;
			test_s1_reg <= test_sig_in;
			test_s2_reg <= test_s1_reg;
		end
	end

	assign pri_steer = state_reg.periph[ASP_PE_PRI_STEER];
	assign sec_steer = state_reg.periph[ASP_PE_SEC_STEER] & ~pri_steer;
	assign digital_test_select      = state_reg.testctl[ASP_TC_SEL_LSB +: 3];
	assign dig_en    = state_reg.testctl[ASP_TC_DIG_EN];
	assign ana_en    = state_reg.testctl[ASP_TC_ANA_EN];

	// ======================================================================
	// Next state.
	always_comb begin
		state_next = state_reg;
		if (bus_req.wr && bus_req.addr == ASP_ADDR_SETPOINT) begin
			state_next.setpoint = bus_req.wdata;
		end
		if (bus_req.wr && bus_req.addr == ASP_ADDR_AUXREF) begin
			state_next.auxref = bus_req.wdata;
		end
		if (bus_req.wr && bus_req.addr == ASP_ADDR_PERIPH_EN) begin
			state_next.periph = bus_req.wdata & ASP_PE_WMASK;
		end
		if (bus_req.wr && bus_req.addr == ASP_ADDR_TEST_CTL) begin
			state_next.testctl = bus_req.wdata & ASP_TC_WMASK;
		end
		state_next.rdata = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				ASP_ADDR_SETPOINT:  state_next.rdata = state_reg.setpoint;
				ASP_ADDR_AUXREF:    state_next.rdata = state_reg.auxref;
				ASP_ADDR_PERIPH_EN: state_next.rdata = state_reg.periph;
				ASP_ADDR_TEST_CTL:  state_next.rdata = state_reg.testctl;
				ASP_ADDR_STATUS:    state_next.rdata = {4'h0,
					state_reg.test_oe, state_reg.pwm_out,
					state_reg.pri_gate, state_reg.sec_gate};
				default:            state_next.rdata = 8'h00;
			endcase
		end
		// period from timer period, duty from timer low byte.
		if (state_reg.pwm_cnt >= timer_period_register) begin
			state_next.pwm_cnt = 8'h00;
		end else begin
			state_next.pwm_cnt = state_reg.pwm_cnt + 8'h01;
		end
		state_next.pwm_out = (state_next.pwm_cnt < timer_low_byte);
		state_next.pri_gate = 1'b0;
		state_next.sec_gate = 1'b0;
		if (pri_steer) begin
			state_next.pri_gate = state_reg.periph[ASP_PE_PRI_EN]
				& state_reg.pwm_out;
		end else if (sec_steer) begin
			state_next.sec_gate = state_reg.periph[ASP_PE_SEC_EN]
				& state_reg.pwm_out & ovp_s2_reg;
		end
		state_next.test_out = 1'b0;
		case (digital_test_select)
			ASP_SEL_DESATURATION_COMPARATOR:   state_next.test_out = test_s2_reg[0];
			ASP_SEL_PWM:     state_next.test_out = test_s2_reg[1];
			ASP_SEL_OVP:     state_next.test_out = test_s2_reg[4];
			ASP_SEL_SWFREQ:  state_next.test_out = test_s2_reg[5];
			ASP_SEL_ONESHOT: state_next.test_out = test_s2_reg[6];
			default:         state_next.test_out = 1'b0;
		endcase
		state_next.test_oe = dig_en;
	end

	// ======================================================================
	// State register.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg.setpoint <= ASP_RST_SETPOINT;
			state_reg.auxref   <= ASP_RST_AUXREF;
			state_reg.periph   <= ASP_RST_PERIPH_EN;
			state_reg.testctl  <= ASP_RST_TEST_CTL;
			state_reg.rdata    <= 8'h00;
			state_reg.pwm_cnt  <= 8'h00;
			state_reg.pwm_out  <= 1'b0;
			state_reg.test_out <= 1'b0;
			state_reg.test_oe  <= 1'b0;
			state_reg.pri_gate <= 1'b0;
			state_reg.sec_gate <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ======================================================================
	// Outputs.
	assign bus_rdata          = state_reg.rdata;
	assign setpoint_code      = state_reg.setpoint;
	assign aux_reference_code = state_reg.auxref;
	assign aux_reference_pin_en = (mode_s2_reg == ASP_MODE_MASTER);
	// dead-time bypass and pull-up pass straight out.
	assign analog_ctl.pri_gate      = state_reg.periph[ASP_PE_PRI_EN];
	assign analog_ctl.sec_gate      = state_reg.periph[ASP_PE_SEC_EN];
	assign analog_ctl.pri_dt_bypass = state_reg.periph[ASP_PE_PRI_BYPASS];
	assign analog_ctl.sec_dt_bypass = state_reg.periph[ASP_PE_SEC_BYPASS];
	assign analog_ctl.sense_pullup  = state_reg.periph[ASP_PE_PULLUP];
	assign primary_gate_output      = state_reg.pri_gate;
	assign secondary_gate_output    = state_reg.sec_gate;
	assign shared_test_pin          = state_reg.test_out;
	assign shared_test_pin_oe       = state_reg.test_oe;
	assign analog_test_to_pin       = ana_en & ~dig_en;
	assign analog_test_to_converter = ana_en & ~dig_en;

endmodule // asp_regs

//--- asp_regs_chk.sv
`timescale 1ns/1ps
module asp_regs_chk
	import asp_pkg::*;
(
	input wire logic            mclk,
	input wire logic            rst,
	input wire asp_bus_req_t    bus_req,
	input wire logic [7:0]      bus_rdata,
	input wire logic [1:0]      operating_mode_select,
	input wire logic [7:0]      setpoint_code,
	input wire asp_analog_ctl_t analog_ctl,
	input wire logic            primary_gate_output,
	input wire logic            secondary_gate_output,
	input wire logic            aux_reference_pin_en,
	input wire logic            shared_test_pin_oe,
	input wire logic            analog_test_to_converter
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic sp_wr;
	logic pe_wr;
	logic tc_wr;
	assign sp_wr = bus_req.wr && bus_req.addr == ASP_ADDR_SETPOINT;
	assign pe_wr = bus_req.wr && bus_req.addr == ASP_ADDR_PERIPH_EN;
	assign tc_wr = bus_req.wr && bus_req.addr == ASP_ADDR_TEST_CTL;
	// ======================================================================
	// Assertions.
	a_setpoint_write:
	assert property (sp_wr |=> setpoint_code == $past(bus_req.wdata))
		else $error("setpoint code not written");
	a_gate_enables:
	assert property (pe_wr |=> {analog_ctl.pri_gate, analog_ctl.sec_gate}
		== $past(bus_req.wdata[7:6])) else $error("gate enables wrong");
	a_bypass_bits:
	assert property (pe_wr |=> {analog_ctl.pri_dt_bypass,
		analog_ctl.sec_dt_bypass} == $past(bus_req.wdata[5:4]))
		else $error("bypass bits wrong");
	a_pullup_bit:
	assert property (pe_wr |=> analog_ctl.sense_pullup
		== $past(bus_req.wdata[2])) else $error("pull-up bit wrong");
	a_pe_bit3_zero:
	assert property (bus_req.rd && bus_req.addr == ASP_ADDR_PERIPH_EN
		|=> !bus_rdata[3]) else $error("unused bit reads one");
	a_steer_exclusive:
	assert property (!(primary_gate_output && secondary_gate_output))
		else $error("both gates steered");
	a_aux_pin_master:
	assert property ((operating_mode_select == ASP_MODE_MASTER) [*5]
		|-> aux_reference_pin_en) else $error("aux pin not routed");
	a_test_oe:
	assert property (tc_wr |=> ##1 shared_test_pin_oe
		== $past(bus_req.wdata[7], 2)) else $error("test pin enable wrong");
	a_analog_route:
	assert property (tc_wr |=> analog_test_to_converter ==
		($past(bus_req.wdata[0]) && !$past(bus_req.wdata[7])))
		else $error("analog route wrong");
	c_primary: cover property (primary_gate_output);
	c_secondary: cover property (secondary_gate_output);
	c_aux_pin: cover property (aux_reference_pin_en);
endmodule // asp_regs_chk

bind asp_regs asp_regs_chk i_chk (.*);

//--- tb.sv
`timescale 1ns/1ps
module tb;
	import asp_pkg::*;
	logic mclk, rst, ovp_active, aux_reference_pin_en;
	asp_bus_req_t bus_req;
	asp_analog_ctl_t analog_ctl;
	logic [1:0] operating_mode_select;
	logic [7:0] bus_rdata, timer_period_register, timer_low_byte;
	logic [7:0] test_sig_in, setpoint_code, aux_reference_code;
	logic primary_gate_output, secondary_gate_output, shared_test_pin;
	logic shared_test_pin_oe, analog_test_to_pin, analog_test_to_converter;
	int failures, check_count, n_pri, n_sec;
	logic e;

	asp_regs i_dut (.*);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] x);
		@(posedge mclk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1 chk(bus_rdata, x);
	endtask
	task automatic run(input int n);
		n_pri = 0;
		n_sec = 0;
		repeat (n) begin
			@(posedge mclk);
			#1;
			n_pri += primary_gate_output;
			n_sec += secondary_gate_output;
		end
	endtask
	task automatic conclude;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#1ms;
		failures++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		bus_req = '0;
		operating_mode_select = 2'h0;
		ovp_active = 1'b0;
		timer_period_register = 8'h04;
		timer_low_byte = 8'h02;
		test_sig_in = 8'hFF;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		for (int a = 0; a < 4; a++) rd(a[3:0], 8'h00);
		$display("test reset done");
		wr(ASP_ADDR_SETPOINT, 8'hA5);
		wr(ASP_ADDR_AUXREF, 8'h5A);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		rd(ASP_ADDR_SETPOINT, 8'hA5);
		rd(ASP_ADDR_AUXREF, 8'h5A);
		chk(aux_reference_code, 8'h5A);
		chk(setpoint_code, 8'hA5);
		wr(ASP_ADDR_PERIPH_EN, 8'hFC);
		#1 chk({3'h0, analog_ctl}, 8'h1F);
		rd(ASP_ADDR_PERIPH_EN, 8'hF4);
		wr(ASP_ADDR_PERIPH_EN, 8'h08);
		#1 chk({3'h0, analog_ctl}, 8'h00);
		rd(ASP_ADDR_PERIPH_EN, 8'h00);
		$display("test registers done");
		// desaturation_comparator source held off while steering.
		@(posedge mclk) test_sig_in <= 8'hFE;
		ovp_active <= 1'b1;
		wr(ASP_ADDR_PERIPH_EN, 8'hC3);
		run(5);
		run(25);
		chk(8'(n_pri), 8'h0A);
		chk(8'(n_sec), 8'h00);
		@(posedge mclk) ovp_active <= 1'b0;
		wr(ASP_ADDR_PERIPH_EN, 8'hC1);
		run(5);
		run(25);
		chk(8'(n_pri + n_sec), 8'h00);
		@(posedge mclk) ovp_active <= 1'b1;
		run(5);
		run(25);
		chk(8'(n_sec), 8'h0A);
		wr(ASP_ADDR_PERIPH_EN, 8'h00);
		$display("test steering done");
		@(posedge mclk) operating_mode_select <= ASP_MODE_MASTER;
		run(5);
		chk({7'h00, aux_reference_pin_en}, 8'h01);
		@(posedge mclk) operating_mode_select <= 2'h2;
		run(5);
		chk({7'h00, aux_reference_pin_en}, 8'h00);
		$display("test aux pin done");
		for (int c = 0; c < 8; c++) begin
			@(posedge mclk) test_sig_in <= 8'h01 << c;
			wr(ASP_ADDR_TEST_CTL, {1'b1, c[2:0], 4'h1});
			run(4);
			e = c inside {0, 1, 4, 5, 6};
			chk({4'h0, shared_test_pin_oe, shared_test_pin, analog_test_to_pin,
				analog_test_to_converter}, {5'h01, e, 2'h0});
		end
		@(posedge mclk) timer_low_byte <= 8'h00;
		run(2);
		rd(ASP_ADDR_STATUS, 8'h08);
		wr(ASP_ADDR_TEST_CTL, 8'h01);
		run(2);
		chk({5'h00, shared_test_pin_oe, analog_test_to_pin,
			analog_test_to_converter}, 8'h03);
		$display("test test pin done");
		conclude();
	end
endmodule // tb
